// ===== dv/multipoint_poll_scheduler_bench.sv
// Self-checking bench for the multipoint poll scheduler
`default_nettype none
module multipoint_poll_scheduler_bench
    import poll_sched_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int UPD   = 64;
    localparam int DEADT = 500;
    logic              sys_clk_in, reset_n_in, ready, desel;
    logic              r_data, r_nodata, r_to, poll_valid, tx_hold;
    logic [CNT_W-1:0]  update_period_in, poll_delay_in;
    logic [7:0]        q_act, r_act, q_ina, r_ina, q_unr, r_unr;
    logic [7:0]        ndm, to_unr, to_dead;
    logic [TRIB_W-1:0] trib, acc_t;
    logic [7:0]        urg [NUM_TRIB];
    logic [7:0]        prev [NUM_TRIB];
    logic [1:0]        answer;
    logic [3:0]        ready_lag, reply_lag;
    integer            seed, fails, checks;
    int                cyc, phase, desels, dpolls, hold_len, dexp, nd;
    int                upd, lastp, last_dead, last_dead_cyc;
    bit                desel_seen, acc_d, dead_ok;
    int                last_inc [NUM_TRIB];
    int                revive [NUM_TRIB];
    poll_state_type    st [NUM_TRIB];
    poll_state_type    st_old [NUM_TRIB];

    poll_scheduler #(.UPDATE_TICKS(CNT_W'(UPD)), .DEAD_TICKS(CNT_W'(DEADT)))
    u_poll_scheduler (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .update_period_in(update_period_in), .poll_delay_in(poll_delay_in),
        .dead_period_in(CNT_W'(0)), // Default, many poll spans
        .q_active_in(q_act), .r_active_in(r_act),
        .q_inactive_in(q_ina), .r_inactive_in(r_ina),
        .q_unresp_in(q_unr), .r_unresp_in(r_unr),
        .ndm_inact_in(ndm), .to_unresp_in(to_unr), .to_dead_in(to_dead),
        .poll_ready_in(ready), .deselect_in(desel),
        .reply_data_in(r_data), .reply_nodata_in(r_nodata),
        .reply_timeout_in(r_to), .poll_valid_out(poll_valid),
        .poll_trib_out(trib), .tx_hold_out(tx_hold), .urgency_out(urg));

    trib_station_model u_trib_station_model (
        .sys_clk_in(sys_clk_in), .poll_valid_in(poll_valid),
        .answer_in(answer), .ready_lag_in(ready_lag),
        .reply_lag_in(reply_lag), .poll_ready_out(ready),
        .deselect_out(desel), .reply_data_out(r_data),
        .reply_nodata_out(r_nodata), .reply_timeout_out(r_to));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] sat(input logic [7:0] a, b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[8] ? 8'hff : s[7:0];
    endfunction : sat

    // Initial value (q set) or increment of a polling state
    function automatic logic [7:0] qr(input poll_state_type s, input bit q);
        case (s)
            ST_ACTIVE:   return q ? q_act : r_act;
            ST_INACTIVE: return q ? q_ina : r_ina;
            ST_UNRESP:   return q ? q_unr : r_unr;
            default:     return 8'h00;
        endcase
    endfunction : qr

    task automatic check(input bit ok, input string msg);
        checks++;
        if (!ok) begin
            fails++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic end_sim;
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    task automatic wait_for(input int sel, input int n);
        int target;
        target = (sel == 0 ? desels : dpolls) + n;
        while ((sel == 0 ? desels : dpolls) < target)
            @(negedge sys_clk_in);
    endtask : wait_for

    ////////////////////////////////////////////////////////////////////////
    // Clock at 40 MHz
    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end

    // Watch delay, urgency steps and each accepted poll
    always @(posedge sys_clk_in) begin
        if (reset_n_in) begin
            cyc++;
            if (desel_seen)
                check(tx_hold === (dexp != 0), "delay start");
            if (tx_hold === 1'b1)
                hold_len++;
            else if (hold_len != 0) begin
                // One extra cycle while the expiry pulse is seen
                check(hold_len == dexp + 1, "delay length");
                hold_len = 0;
            end
            if (tx_hold === 1'b1)
                check(poll_valid !== 1'b1, "poll in delay");
            desel_seen = (desel === 1'b1);
            if (desel_seen) begin
                desels++;
                dexp = int'(poll_delay_in);
            end
            for (int i = 0; i < NUM_TRIB; i++) begin
                if (acc_d && acc_t == i) begin
                    if (st_old[i] != ST_DEAD)
                        check(urg[i] === qr(st_old[i], 1), "reload");
                    last_inc[i] = 0;
                end else if (urg[i] !== prev[i]) begin
                    check(urg[i] === sat(prev[i], qr(st[i], 0)) ||
                          urg[i] === sat(prev[i], qr(st_old[i], 0)),
                          "step");
                    if (last_inc[i] != 0)
                        check(cyc - last_inc[i] inside {[upd-12:upd+12]},
                              "tick gap");
                    last_inc[i] = cyc;
                end
                prev[i] = urg[i];
            end
            acc_d = (poll_valid === 1'b1 && ready === 1'b1);
            if (acc_d) begin
                acc_t = trib;
                if (st[trib] != ST_DEAD)
                    check(urg[trib] >= URG_THRESHOLD, "early poll");
                if (phase == 1 && lastp >= 0)
                    check(trib === TRIB_W'((lastp + 1) % NUM_TRIB), "order");
                if (st[trib] == ST_DEAD) begin
                    if (dead_ok && nd == NUM_TRIB) begin
                        check(trib === TRIB_W'((last_dead + 1) % NUM_TRIB),
                              "dead order");
                        check(cyc - last_dead_cyc inside {[DEADT-40:DEADT+40]},
                              "dead gap");
                        dpolls++;
                    end
                    dead_ok = (nd == NUM_TRIB);
                    last_dead = int'(trib);
                    last_dead_cyc = cyc;
                end
                if (revive[trib] != 0)
                    check(cyc - revive[trib] < 1600, "revive");
                revive[trib] = 0;
                st_old[trib] = st[trib];
                if (answer == 2'd0 || (answer == 2'd1 && st[trib] == ST_DEAD))
                    st[trib] = ST_ACTIVE;
                else if (answer == 2'd1 && st[trib] == ST_ACTIVE)
                    st[trib] = ST_INACTIVE;
                else if (answer == 2'd2 && st[trib] == ST_UNRESP)
                    st[trib] = ST_DEAD;
                else if (answer == 2'd2 && st[trib] != ST_DEAD)
                    st[trib] = ST_UNRESP;
                if (st_old[trib] == ST_DEAD && st[trib] == ST_ACTIVE)
                    revive[trib] = cyc;
                nd += int'(st[trib] == ST_DEAD) - int'(st_old[trib] == ST_DEAD);
                lastp = int'(trib);
            end
        end
    end

    // Vary the far side's pace and the poll delay between exchanges
    always @(negedge sys_clk_in) begin
        if (desel_seen) begin
            ready_lag <= 4'($random(seed));
            reply_lag <= 4'($random(seed));
            if (phase >= 2)
                poll_delay_in <= CNT_W'({$random(seed)} % 21);
        end
    end

    // Main sequence: defaults, random delay, no-data, silence, revival
    initial begin
        seed = 32'h5c76;
        {fails, checks, cyc, phase, desels, dpolls, hold_len, dexp, nd} = '0;
        {desel_seen, acc_d, dead_ok, acc_t} = '0;
        {lastp, last_dead, last_dead_cyc} = {-1, -1, 0};
        for (int i = 0; i < NUM_TRIB; i++) begin
            {prev[i], last_inc[i], revive[i]} = '0;
            {st[i], st_old[i]} = {ST_ACTIVE, ST_ACTIVE};
        end
        reset_n_in = 1'b0;
        upd = UPD + ({$random(seed)} % 8);
        update_period_in = CNT_W'(upd);
        poll_delay_in = CNT_W'(POLL_DELAY_DEF);
        {q_act, r_act} = {Q_DEF, R_DEF};
        q_ina = 8'($random(seed)) & 8'h7f;
        r_ina = 8'h10 | (8'($random(seed)) & 8'h3f);
        q_unr = 8'($random(seed)) & 8'h7f;
        r_unr = 8'h40 + (8'($random(seed)) & 8'h7f);
        ndm = 8'($random(seed)) & 8'h01;
        to_unr = 8'($random(seed)) & 8'h01;
        to_dead = 8'($random(seed)) & 8'h01;
        {answer, ready_lag, reply_lag} = '0;
        repeat (4) @(negedge sys_clk_in);
        reset_n_in = 1'b1;
        phase = 1;
        wait_for(0, 24);
        phase = 2;
        wait_for(0, 16);
        answer = 2'd1;
        wait_for(0, 14);
        answer = 2'd2;
        wait_for(1, 4);
        wait_for(0, 1);
        answer = 2'd0;
        wait_for(0, 8);
        repeat (1700) @(negedge sys_clk_in);
        for (int i = 0; i < NUM_TRIB; i++)
            if (revive[i] != 0)
                check(cyc - revive[i] < 1600, "no revive poll");
        end_sim();
    end

    // Cut a hang short: the sequence needs about a sixth of this span
    initial begin
        repeat (80000) @(posedge sys_clk_in);
        fails++;
        $display("MISMATCH at %0t: watchdog", $time);
        end_sim();
    end
endmodule : multipoint_poll_scheduler_bench
`default_nettype wire

// ===== dv/trib_station_model.sv
// Behavioural tributary stations answering polls on the shared line
`default_nettype none
module trib_station_model (
    input  wire logic       sys_clk_in,
    input  wire logic       poll_valid_in,
    input  wire logic [1:0] answer_in,     // 0 data, 1 no data, 2 silent
    input  wire logic [3:0] ready_lag_in,  // Cycles before taking a poll
    input  wire logic [3:0] reply_lag_in,  // Cycles from poll to reply
    output var  logic       poll_ready_out,
    output var  logic       deselect_out,
    output var  logic       reply_data_out,
    output var  logic       reply_nodata_out,
    output var  logic       reply_timeout_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Take a poll after a lag, give one reply, then deselect
    initial begin
        {poll_ready_out, deselect_out} = 2'b00;
        {reply_data_out, reply_nodata_out, reply_timeout_out} = 3'b000;
        forever begin
            @(negedge sys_clk_in);
            if (poll_valid_in === 1'b1) begin
                repeat (ready_lag_in) @(negedge sys_clk_in);
                poll_ready_out = 1'b1;  // Held over one sampling edge
                @(negedge sys_clk_in);
                poll_ready_out = 1'b0;
                repeat (reply_lag_in) @(negedge sys_clk_in);
                reply_data_out    = (answer_in == 2'd0);
                reply_nodata_out  = (answer_in == 2'd1);
                reply_timeout_out = (answer_in == 2'd2);
                @(negedge sys_clk_in);
                {reply_data_out, reply_nodata_out, reply_timeout_out} = 3'b000;
                deselect_out = 1'b1;  // Reply always lands before deselect
                @(negedge sys_clk_in);
                deselect_out = 1'b0;
            end
        end
    end
endmodule : trib_station_model
`default_nettype wire

// ===== rtl/poll_sched_pkg.sv
// Constants and types of the multipoint poll scheduler
// How it works
// - Update period defaults 200 ms, never shorter
// - Update pass refreshes 12 tributaries per period
// - Eligible only once urgency reaches 128
// - Maximum urgency not a guarantee of polling
// - Default values in active state give round-robin
// - Poll delay separates polls, holds transmission
// - Poll delay starts at tributary deselect
// - Poll delay defaults to zero, no gap
// - Dead tributaries round-robin, one per expiry
// - Dead timer defaults to ten seconds
// - Tick adds state increment; poll reloads initial
// - Scan after last polled; 255 stops scan
// - State follows reply and timeout thresholds
`default_nettype none
package poll_sched_pkg;
    localparam int          NUM_TRIB       = 12;
    localparam int          TRIB_W         = 4;
    localparam int          CNT_W          = 32;
    localparam int          CLK_HZ         = 40_000_000;
    localparam int          UPDATE_MS      = 200;
    localparam int          DEAD_S         = 10;
    localparam int          UPDATE_CYC     = CLK_HZ / 1000 * UPDATE_MS;
    localparam int          DEAD_CYC       = CLK_HZ * DEAD_S;
    localparam int          POLL_DELAY_DEF = 0;
    localparam logic [7:0]  URG_THRESHOLD  = 8'h80;
    localparam logic [7:0]  URG_MAX        = 8'hff;
    localparam logic [7:0]  Q_DEF          = 8'h00;
    localparam logic [7:0]  R_DEF          = 8'h08;
    localparam logic [7:0]  LIMIT_DEF      = 8'h03;
    typedef enum logic [1:0] {
        ST_ACTIVE, ST_INACTIVE, ST_UNRESP, ST_DEAD
    } poll_state_type;
endpackage : poll_sched_pkg
`default_nettype wire

// ===== rtl/poll_scheduler.sv
// Control-station polling scheduler for a multipoint line
`default_nettype none
module poll_scheduler
    import poll_sched_pkg::*;
#(
    parameter logic [CNT_W-1:0] UPDATE_TICKS = CNT_W'(UPDATE_CYC),
    parameter logic [CNT_W-1:0] DEAD_TICKS   = CNT_W'(DEAD_CYC)
)(
    input  wire logic              sys_clk_in,
    input  wire logic              reset_n_in,
    input  wire logic [CNT_W-1:0]  update_period_in,
    input  wire logic [CNT_W-1:0]  poll_delay_in,
    input  wire logic [CNT_W-1:0]  dead_period_in,
    input  wire logic [7:0]        q_active_in,
    input  wire logic [7:0]        r_active_in,
    input  wire logic [7:0]        q_inactive_in,
    input  wire logic [7:0]        r_inactive_in,
    input  wire logic [7:0]        q_unresp_in,
    input  wire logic [7:0]        r_unresp_in,
    input  wire logic [7:0]        ndm_inact_in,
    input  wire logic [7:0]        to_unresp_in,
    input  wire logic [7:0]        to_dead_in,
    input  wire logic              poll_ready_in,
    input  wire logic              deselect_in,
    input  wire logic              reply_data_in,
    input  wire logic              reply_nodata_in,
    input  wire logic              reply_timeout_in,
    output logic                   poll_valid_out,
    output logic [TRIB_W-1:0]      poll_trib_out,
    output logic                   tx_hold_out,
    output logic [7:0]             urgency_out [NUM_TRIB]
);
    typedef enum logic [2:0] {
        S_IDLE, S_SCAN, S_ISSUE, S_WAIT, S_DELAY
    } sched_state_type;

    sched_state_type   fsm_reg;
    poll_state_type    pstate_reg [NUM_TRIB];
    logic [7:0]        urg_reg    [NUM_TRIB];
    logic [7:0]        cnt_reg    [NUM_TRIB];
    logic [TRIB_W-1:0] upd_idx_reg, scan_idx_reg, scan_n_reg;
    logic [TRIB_W-1:0] last_reg, dead_last_reg, best_reg, cur_reg;
    logic [7:0]        best_urg_reg;
    logic              best_ok_reg, updating_reg, dead_pend_reg;
    logic              is_dead_poll_reg;
    logic              upd_tick, dead_tick, delay_tick, delay_start;
    logic              take_here;
    logic [CNT_W-1:0]  upd_period, dead_period;

    // Update period below the floor is raised to it; a zero dead period takes the default
    assign upd_period  = (update_period_in < UPDATE_TICKS) ?
                         UPDATE_TICKS : update_period_in;
    assign dead_period = (dead_period_in == '0) ?
                         DEAD_TICKS : dead_period_in;

    ////////////////////////////////////////////////////////////////////
    // Timers
    tick_timer u_update (
        .sys_clk_in (sys_clk_in),
        .reset_n_in (reset_n_in),
        .restart_in (1'b0),
        .period_in  (upd_period),
        .expire_out (upd_tick)
    );
    tick_timer u_dead (
        .sys_clk_in (sys_clk_in),
        .reset_n_in (reset_n_in),
        .restart_in (1'b0),
        .period_in  (dead_period),
        .expire_out (dead_tick)
    );
    assign delay_start = fsm_reg == S_WAIT && deselect_in;

    // Entry under the scan is eligible and beats the best so far
    assign take_here = pstate_reg[scan_idx_reg] != ST_DEAD &&
                       urg_reg[scan_idx_reg] >= URG_THRESHOLD &&
                       (!best_ok_reg ||
                        urg_reg[scan_idx_reg] > best_urg_reg);
    tick_timer u_delay (
        .sys_clk_in (sys_clk_in),
        .reset_n_in (reset_n_in),
        .restart_in (delay_start),
        .period_in  (poll_delay_in),
        .expire_out (delay_tick)
    );

    // Increment for a state
    function automatic logic [7:0] rate_of(poll_state_type s);
        unique case (s)
            ST_ACTIVE:   rate_of = r_active_in;
            ST_INACTIVE: rate_of = r_inactive_in;
            ST_UNRESP:   rate_of = r_unresp_in;
            ST_DEAD:     rate_of = 8'h00;
        endcase
    endfunction : rate_of

    // Initial urgency for a state
    function automatic logic [7:0] init_of(poll_state_type s);
        unique case (s)
            ST_ACTIVE:   init_of = q_active_in;
            ST_INACTIVE: init_of = q_inactive_in;
            ST_UNRESP:   init_of = q_unresp_in;
            ST_DEAD:     init_of = 8'h00;
        endcase
    endfunction : init_of

    // Saturating add keeps the urgency byte from wrapping
    function automatic logic [7:0] sat_add(logic [7:0] a, logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[8] ? URG_MAX : s[7:0];
    endfunction : sat_add

    // Next index, wrapping at the tributary count
    function automatic logic [TRIB_W-1:0] nxt(logic [TRIB_W-1:0] i);
        nxt = (i == TRIB_W'(NUM_TRIB - 1)) ? '0 : i + 1'b1;
    endfunction : nxt

    ////////////////////////////////////////////////////////////////////
    // Update pass: one tributary per clock, 12 clocks per tick
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            updating_reg <= 1'b0;
            upd_idx_reg  <= '0;
        end else if (upd_tick) begin
            updating_reg <= 1'b1;
            upd_idx_reg  <= '0;
        end else if (updating_reg) begin
            updating_reg <= upd_idx_reg != TRIB_W'(NUM_TRIB - 1);
            upd_idx_reg  <= nxt(upd_idx_reg);
        end
    end

    // Urgency store: polled reload wins over increment
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < NUM_TRIB; i++) begin
                urg_reg[i] <= Q_DEF;
            end
        end else begin
            for (int i = 0; i < NUM_TRIB; i++) begin
                if (fsm_reg == S_ISSUE && poll_ready_in &&
                    cur_reg == TRIB_W'(i)) begin
                    urg_reg[i] <= init_of(pstate_reg[i]);
                end else if (updating_reg && upd_idx_reg == TRIB_W'(i) &&
                             pstate_reg[i] != ST_DEAD) begin
                    urg_reg[i] <= sat_add(urg_reg[i],
                                          rate_of(pstate_reg[i]));
                end
            end
        end
    end
    assign urgency_out = urg_reg;

    ////////////////////////////////////////////////////////////////////
    // Polling state per tributary from reply outcome
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < NUM_TRIB; i++) begin
                pstate_reg[i] <= ST_ACTIVE;
                cnt_reg[i]    <= '0;
            end
        end else if (fsm_reg == S_WAIT) begin
            if (reply_data_in) begin
                pstate_reg[cur_reg] <= ST_ACTIVE;
                cnt_reg[cur_reg]    <= '0;
            end else if (reply_nodata_in) begin
                if (pstate_reg[cur_reg] == ST_DEAD) begin
                    pstate_reg[cur_reg] <= ST_ACTIVE;
                    cnt_reg[cur_reg]    <= '0;
                end else if (pstate_reg[cur_reg] == ST_ACTIVE) begin
                    if (cnt_reg[cur_reg] + 8'h01 >= ndm_inact_in) begin
                        pstate_reg[cur_reg] <= ST_INACTIVE;
                        cnt_reg[cur_reg]    <= '0;
                    end else begin
                        cnt_reg[cur_reg] <= cnt_reg[cur_reg] + 8'h01;
                    end
                end
            end else if (reply_timeout_in &&
                         pstate_reg[cur_reg] != ST_DEAD) begin
                if (pstate_reg[cur_reg] == ST_UNRESP &&
                    cnt_reg[cur_reg] + 8'h01 >= to_dead_in) begin
                    pstate_reg[cur_reg] <= ST_DEAD;
                    cnt_reg[cur_reg]    <= '0;
                end else if (pstate_reg[cur_reg] != ST_UNRESP &&
                             cnt_reg[cur_reg] + 8'h01 >= to_unresp_in) begin
                    pstate_reg[cur_reg] <= ST_UNRESP;
                    cnt_reg[cur_reg]    <= '0;
                end else begin
                    cnt_reg[cur_reg] <= cnt_reg[cur_reg] + 8'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Dead expiry is held until it is served
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dead_pend_reg <= 1'b0;
        end else if (dead_tick) begin
            dead_pend_reg <= 1'b1; // set wins over serve
        end else if (fsm_reg == S_IDLE && dead_pend_reg) begin
            dead_pend_reg <= 1'b0; // Handed to the scan now starting
        end
    end

    // Sequencer: scan, issue, wait deselect, poll delay
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fsm_reg          <= S_IDLE;
            scan_idx_reg     <= '0;
            scan_n_reg       <= '0;
            best_reg         <= '0;
            best_urg_reg     <= '0;
            best_ok_reg      <= 1'b0;
            last_reg         <= TRIB_W'(NUM_TRIB - 1);
            dead_last_reg    <= TRIB_W'(NUM_TRIB - 1);
            cur_reg          <= '0;
            is_dead_poll_reg <= 1'b0;
        end else begin
            unique case (fsm_reg)
                S_IDLE: begin
                    fsm_reg      <= S_SCAN;
                    scan_idx_reg <= dead_pend_reg ? nxt(dead_last_reg)
                                                  : nxt(last_reg);
                    scan_n_reg   <= '0;
                    best_ok_reg  <= 1'b0;
                    best_urg_reg <= '0;
                    is_dead_poll_reg <= dead_pend_reg;
                end
                S_SCAN: begin
                    if (is_dead_poll_reg) begin
                        // First dead one after the last dead polled
                        if (pstate_reg[scan_idx_reg] == ST_DEAD) begin
                            cur_reg       <= scan_idx_reg;
                            dead_last_reg <= scan_idx_reg;
                            fsm_reg       <= S_ISSUE;
                        end else if (scan_n_reg ==
                                     TRIB_W'(NUM_TRIB - 1)) begin
                            fsm_reg <= S_IDLE;
                        end
                    end else if (pstate_reg[scan_idx_reg] != ST_DEAD &&
                                 urg_reg[scan_idx_reg] == URG_MAX) begin
                        cur_reg <= scan_idx_reg;
                        fsm_reg <= S_ISSUE;
                    end else begin
                        // Strict greater keeps ties in scan order
                        if (take_here) begin
                            best_ok_reg  <= 1'b1;
                            best_reg     <= scan_idx_reg;
                            best_urg_reg <= urg_reg[scan_idx_reg];
                        end
                        // Last entry counts before the choice is made
                        if (scan_n_reg == TRIB_W'(NUM_TRIB - 1)) begin
                            cur_reg <= take_here ? scan_idx_reg : best_reg;
                            fsm_reg <= (take_here || best_ok_reg) ? S_ISSUE
                                                                  : S_IDLE;
                        end
                    end
                    scan_idx_reg <= nxt(scan_idx_reg);
                    scan_n_reg   <= scan_n_reg + 1'b1;
                end
                S_ISSUE: begin
                    if (poll_ready_in) begin
                        if (!is_dead_poll_reg) begin
                            last_reg <= cur_reg;
                        end
                        fsm_reg <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (deselect_in) begin
                        fsm_reg <= (poll_delay_in == '0) ? S_IDLE
                                                         : S_DELAY;
                    end
                end
                S_DELAY: begin
                    if (delay_tick) begin
                        fsm_reg <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // Poll request and transmit hold
    assign poll_valid_out = fsm_reg == S_ISSUE;
    assign poll_trib_out  = cur_reg;
    assign tx_hold_out    = fsm_reg == S_DELAY;

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_delay_holds_tx:
        assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
            fsm_reg == S_DELAY |-> !poll_valid_out && tx_hold_out)
        else $error("poll issued during poll delay");
    a_zero_delay_gap:
        assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
            (fsm_reg == S_WAIT && deselect_in && poll_delay_in == '0)
            |=> fsm_reg == S_IDLE)
        else $error("zero poll delay inserted a gap");
    a_delay_starts:
        assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
            $rose(tx_hold_out) |-> $past(deselect_in))
        else $error("poll delay began without deselect");
    a_poll_eligible:
        assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
            $rose(poll_valid_out) && !is_dead_poll_reg |->
            urg_reg[cur_reg] >= URG_THRESHOLD)
        else $error("polled tributary below threshold");
    a_dead_poll:
        assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
            $rose(poll_valid_out) && is_dead_poll_reg |->
            pstate_reg[cur_reg] == ST_DEAD)
        else $error("dead slot polled a live tributary");
    a_update_pass:
        assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
            upd_tick |-> ##12 (updating_reg &&
            upd_idx_reg == TRIB_W'(NUM_TRIB - 1)) ##1 !updating_reg)
        else $error("update pass length wrong");
    a_no_wrap:
        assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
            $past(urg_reg[0]) == URG_MAX && !$past(poll_valid_out)
            |-> urg_reg[0] == URG_MAX)
        else $error("urgency wrapped");
    a_reload_q:
        assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
            poll_valid_out && poll_ready_in && cur_reg == '0 &&
            pstate_reg[0] == ST_ACTIVE |=> urg_reg[0] == q_active_in)
        else $error("urgency not reloaded after poll");
endmodule : poll_scheduler
`default_nettype wire

// ===== rtl/tick_timer.sv
// Programmable down-counter that pulses once per expiry
`default_nettype none
module tick_timer
    import poll_sched_pkg::*;
(
    input  wire logic             sys_clk_in,
    input  wire logic             reset_n_in,
    input  wire logic             restart_in,
    input  wire logic [CNT_W-1:0] period_in,
    output var  logic             expire_out
);
    logic [CNT_W-1:0] count_reg;

    // Reload on restart or expiry, otherwise count down
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_reg  <= '0;
            expire_out <= 1'b0;
        end else if (restart_in || count_reg == '0) begin
            count_reg  <= (period_in == '0) ? '0 : period_in - 1'b1;
            expire_out <= !restart_in; // Fires even if the period moved
        end else begin
            count_reg  <= count_reg - 1'b1;
            expire_out <= 1'b0;
        end
    end
endmodule : tick_timer
`default_nettype wire
